/* shared/lpo_pkg.sv */
// Purpose: constants, register map and types of the panel output formatter
// Assumes: 32-bit register port with byte addresses, one register per aligned word
// Notes:   timing fields count pixel clocks (columns) and lines
package lpo_pkg;

  localparam int unsigned CORE_MHZ      = 50;
  localparam int unsigned CPU_PHASE_NS  = 40;
  localparam int unsigned CPU_PHASE_CYC = (CPU_PHASE_NS * CORE_MHZ + 999) / 1000;
  localparam int unsigned QUEUE_DEPTH   = 16;
  localparam int unsigned QUEUE_AW      = 4;
  localparam int unsigned GAMMA_POINTS  = 33;

  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_HTIM    = 8'h04;
  localparam logic [7:0] REG_HACT    = 8'h08;
  localparam logic [7:0] REG_VTIM    = 8'h0C;
  localparam logic [7:0] REG_VACT    = 8'h10;
  localparam logic [7:0] REG_BG      = 8'h14;
  localparam logic [7:0] REG_BRIGHT  = 8'h18;
  localparam logic [7:0] REG_CLIP_LO = 8'h1C;
  localparam logic [7:0] REG_CLIP_HI = 8'h20;
  localparam logic [7:0] REG_PLANE_X = 8'h24;
  localparam logic [7:0] REG_PLANE_Y = 8'h28;
  localparam logic [7:0] REG_PARTIAL = 8'h2C;
  localparam logic [7:0] REG_STN_HS  = 8'h30;
  localparam logic [7:0] REG_CMD     = 8'h34;
  localparam logic [7:0] REG_GAMMA   = 8'h38;
  localparam logic [7:0] REG_STATUS  = 8'h3C;

  // panel_control_cfg / display_interface_cfg bits in the control register, then command, gamma, high-field and status bit positions
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_MODE_LSB    = 1;
  localparam int unsigned CTRL_WIDTH24_BIT = 3;
  localparam int unsigned CTRL_SWAP_BIT    = 4;
  localparam int unsigned CTRL_PM16_BIT    = 5;
  localparam int unsigned CTRL_PM18_BIT    = 6;
  localparam int unsigned CTRL_GENERAL_OUTPUT_SELECT_BIT   = 7;
  localparam int unsigned CTRL_DEINV_BIT   = 8;
  localparam int unsigned CTRL_HSINV_BIT   = 9;
  localparam int unsigned CTRL_VSINV_BIT   = 10;
  localparam int unsigned CTRL_CPU16_BIT   = 11;
  localparam int unsigned CTRL_GAMMA_BIT   = 12;
  localparam int unsigned CTRL_PART_BIT    = 13;
  localparam int unsigned CTRL_FMT_LSB     = 14;
  localparam int unsigned CTRL_GPVAL_LSB   = 16;
  localparam int unsigned CMD_DATA_BIT     = 16;
  localparam int unsigned GAMMA_IDX_LSB    = 8;
  localparam int unsigned HI_FIELD_LSB     = 16;
  localparam int unsigned STAT_EMPTY_BIT   = 16;
  localparam int unsigned STAT_FULL_BIT    = 17;
  localparam int unsigned STAT_LVL_LSB     = 20;

  // reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] HTIM_RST    = 32'h0010_0804;
  localparam logic [31:0] HACT_RST    = 32'h0000_0140;
  localparam logic [31:0] VTIM_RST    = 32'h0004_0202;
  localparam logic [31:0] VACT_RST    = 32'h0000_00F0;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  localparam logic [31:0] CLIP_HI_RST = 32'h00FF_FFFF;
  localparam logic [31:0] WIN_RST     = 32'h0FFF_0000;

  typedef enum logic [1:0] {
    MODE_TFT   = 2'b00,
    MODE_STN   = 2'b01,
    MODE_CPU68 = 2'b10,
    MODE_CPU80 = 2'b11
  } lpo_mode_t;

  typedef enum logic [1:0] {
    FMT_666  = 2'b00,
    FMT_565  = 2'b01,
    FMT_888P = 2'b10,
    FMT_888U = 2'b11
  } lpo_fmt_t;

  typedef enum logic [1:0] {
    CPU_IDLE   = 2'b00,
    CPU_SETUP  = 2'b01,
    CPU_STROBE = 2'b10,
    CPU_HOLD   = 2'b11
  } lpo_cpu_t;

endpackage

/* design/lpo_formatter.sv */
// Purpose: panel output formatter for TFT, color STN and CPU-type panels
// Assumes: panel_pixel_clock_in comes from outside and is sampled by core_clk
// Notes:   pixel source holds pix_valid/pix_data until the one-cycle pix_ack
//
// The implementer's own choices: the strobed register port and the register offsets.
module lpo_formatter
  import lpo_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [23:0] pix_data,
  input  wire logic        pix_valid,
  output logic             pix_ack,
  input  wire logic        panel_pixel_clock_in,
  output logic             panel_pixel_clock,
  output logic      [23:0] panel_data_bus,
  output logic             control_pin_0,
  output logic             control_pin_1,
  output logic             control_pin_2,
  output logic             control_pin_3,
  output logic      [3:0]  control_pin_upper
);

  function automatic logic [23:0] expand(input logic [1:0] fmt, input logic [23:0] d);
    case (fmt)
      FMT_666: expand = {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
      FMT_565: expand = {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
      default: expand = d;
    endcase
  endfunction

  function automatic logic [7:0] bright(input logic [7:0] c, input logic [7:0] off);
    logic signed [9:0] s;
    s = $signed({2'b00, c}) + $signed({{2{off[7]}}, off});
    bright = s < 0 ? 8'h00 : (s > 10'sd255 ? 8'hFF : s[7:0]);
  endfunction

  function automatic logic [7:0] gam(input logic [7:0] x, input logic [7:0] lo, input logic [7:0] hi);
    logic signed [8:0]  d;
    logic signed [12:0] p;
    d = $signed({1'b0, hi}) - $signed({1'b0, lo});
    p = (13'(d) * $signed({10'd0, x[2:0]})) >>> 3;
    gam = 8'(13'($signed({5'd0, lo})) + p);
  endfunction

  function automatic logic [7:0] clip(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    clip = c < lo ? lo : (c > hi ? hi : c);
  endfunction

  function automatic logic [23:0] tft_pack(input logic [23:0] rgb, input logic w24, input logic swap,
                                           input logic pm18, input logic pm16);
    logic [7:0] a;
    logic [7:0] g;
    logic [7:0] c;
    a = swap ? rgb[7:0] : rgb[23:16];
    g = rgb[15:8];
    c = swap ? rgb[23:16] : rgb[7:0];
    if (w24) begin
      tft_pack = {a, g, c};
    end else if (pm18) begin
      tft_pack = {a[7:2], a[7:6], g[7:2], g[7:6], c[7:2], c[7:6]};
    end else if (pm16) begin
      tft_pack = {a[7:3], a[7:5], g[7:2], g[7:6], c[7:3], c[7:5]};
    end else begin
      tft_pack = {6'd0, a[7:6], a[5:2], g[7:4], g[3:2], c[7:2]};
    end
  endfunction

  logic [31:0] ctrl_q, htim_q, hact_q, vtim_q, vact_q, bg_q, bright_q;
  logic [31:0] clip_lo_q, clip_hi_q, plane_x_q, plane_y_q, partial_q, stn_hs_q;
  logic [7:0]  gamma_q [GAMMA_POINTS];
  logic [16:0] queue_q [QUEUE_DEPTH];
  logic [QUEUE_AW:0] wptr_q, rptr_q;
  logic        pclk_s1_q, pclk_s2_q, pclk_s3_q;
  logic [11:0] h_cnt_q, v_cnt_q;
  logic        hs_q, vs_q, de_q;
  logic [10:0] sbuf_q;
  logic [3:0]  scnt_q;
  lpo_cpu_t    cpu_st_q;
  logic [3:0]  phase_q;
  logic        rs_q;

  wire       en      = ctrl_q[CTRL_EN_BIT];
  wire [1:0] mode    = ctrl_q[CTRL_MODE_LSB +: 2];
  wire       is_tft  = mode == MODE_TFT;
  wire       is_stn  = mode == MODE_STN;
  wire       is_cpu  = mode[1];
  wire       gp_sel  = ctrl_q[CTRL_GENERAL_OUTPUT_SELECT_BIT];
  wire       pix_tick = pclk_s2_q & ~pclk_s3_q;

  // timing geometry, all in pixel clocks and lines
  wire [11:0] hsw     = 12'(htim_q[7:0]);
  wire [11:0] h_start = 12'(htim_q[7:0]) + 12'(htim_q[15:8]);
  wire [11:0] h_end   = h_start + hact_q[11:0];
  wire [11:0] h_total = h_end + 12'(htim_q[23:16]);
  wire [11:0] vsync_length     = 12'(vtim_q[7:0]);
  wire [11:0] v_start = 12'(vtim_q[7:0]) + 12'(vtim_q[15:8]);
  wire [11:0] v_end   = v_start + vact_q[11:0];
  wire [11:0] v_total = v_end + 12'(vtim_q[23:16]);
  wire [11:0] x_pos   = h_cnt_q - h_start;
  wire [11:0] y_pos   = v_cnt_q - v_start;
  wire        line_act = h_cnt_q >= h_start && h_cnt_q < h_end && v_cnt_q >= v_start && v_cnt_q < v_end;
  wire        in_part  = !ctrl_q[CTRL_PART_BIT] ||
                         (y_pos >= partial_q[11:0] && y_pos <= partial_q[HI_FIELD_LSB +: 12]);
  wire        active   = line_act && in_part;
  wire        in_plane = x_pos >= plane_x_q[11:0] && x_pos <= plane_x_q[HI_FIELD_LSB +: 12] &&
                         y_pos >= plane_y_q[11:0] && y_pos <= plane_y_q[HI_FIELD_LSB +: 12];

  // pixel path: format expand, brightness, gamma, clip
  logic [23:0] px_rgb;
  logic [23:0] px_out;
  always_comb begin
    logic [7:0] c;
    logic [5:0] gi;
    c      = 8'h00;
    gi     = 6'd0;
    px_rgb = expand(ctrl_q[CTRL_FMT_LSB +: 2], pix_data);
    px_out = 24'h0;
    for (int i = 0; i < 3; i++) begin
      c  = bright(px_rgb[16 - 8 * i +: 8], bright_q[7:0]);
      gi = {1'b0, c[7:3]};
      if (ctrl_q[CTRL_GAMMA_BIT]) begin
        c = gam(c, gamma_q[gi], gamma_q[6'(gi + 6'd1)]);
      end
      px_out[16 - 8 * i +: 8] = clip(c, clip_lo_q[16 - 8 * i +: 8], clip_hi_q[16 - 8 * i +: 8]);
    end
  end

  wire [23:0] tft_px  = tft_pack(px_out, ctrl_q[CTRL_WIDTH24_BIT], ctrl_q[CTRL_SWAP_BIT],
                                 ctrl_q[CTRL_PM18_BIT], ctrl_q[CTRL_PM16_BIT]);
  wire [23:0] tft_bg  = tft_pack(bg_q[23:0], ctrl_q[CTRL_WIDTH24_BIT], ctrl_q[CTRL_SWAP_BIT],
                                 ctrl_q[CTRL_PM18_BIT], ctrl_q[CTRL_PM16_BIT]);
  wire        tft_take  = en && is_tft && pix_tick && active && in_plane && pix_valid && !pix_ack;
  wire        stn_fetch = en && is_stn && !pix_tick && line_act && scnt_q < 4'd8 && pix_valid && !pix_ack;
  wire        stn_emit  = en && is_stn && pix_tick && line_act && scnt_q >= 4'd8;
  wire [QUEUE_AW:0] q_lvl = wptr_q - rptr_q;
  wire        q_empty = q_lvl == '0;
  wire        q_full  = q_lvl == (QUEUE_AW + 1)'(QUEUE_DEPTH);
  wire        q_push  = reg_wr && reg_addr == REG_CMD && !q_full;
  wire        q_pop   = en && is_cpu && cpu_st_q == CPU_IDLE && !q_empty;
  wire [16:0] q_head  = queue_q[rptr_q[QUEUE_AW-1:0]];

  // register writes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_q    <= CTRL_RST;
      htim_q    <= HTIM_RST;
      hact_q    <= HACT_RST;
      vtim_q    <= VTIM_RST;
      vact_q    <= VACT_RST;
      bg_q      <= ZERO_RST;
      bright_q  <= ZERO_RST;
      clip_lo_q <= ZERO_RST;
      clip_hi_q <= CLIP_HI_RST;
      plane_x_q <= WIN_RST;
      plane_y_q <= WIN_RST;
      partial_q <= WIN_RST;
      stn_hs_q  <= ZERO_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:    ctrl_q    <= reg_wdata;
        REG_HTIM:    htim_q    <= reg_wdata;
        REG_HACT:    hact_q    <= reg_wdata;
        REG_VTIM:    vtim_q    <= reg_wdata;
        REG_VACT:    vact_q    <= reg_wdata;
        REG_BG:      bg_q      <= reg_wdata;
        REG_BRIGHT:  bright_q  <= reg_wdata;
        REG_CLIP_LO: clip_lo_q <= reg_wdata;
        REG_CLIP_HI: clip_hi_q <= reg_wdata;
        REG_PLANE_X: plane_x_q <= reg_wdata;
        REG_PLANE_Y: plane_y_q <= reg_wdata;
        REG_PARTIAL: partial_q <= reg_wdata;
        REG_STN_HS:  stn_hs_q  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // gamma points, identity curve after reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < GAMMA_POINTS; i++) begin
        gamma_q[i] <= (i == GAMMA_POINTS - 1) ? 8'hFF : 8'(i * 8);
      end
    end else if (reg_wr && reg_addr == REG_GAMMA && reg_wdata[GAMMA_IDX_LSB +: 6] < 6'(GAMMA_POINTS)) begin
      gamma_q[reg_wdata[GAMMA_IDX_LSB +: 6]] <= reg_wdata[7:0];
    end
  end

  // register reads, data in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:    reg_rdata <= ctrl_q;
        REG_HTIM:    reg_rdata <= htim_q;
        REG_HACT:    reg_rdata <= hact_q;
        REG_VTIM:    reg_rdata <= vtim_q;
        REG_VACT:    reg_rdata <= vact_q;
        REG_BG:      reg_rdata <= bg_q;
        REG_BRIGHT:  reg_rdata <= bright_q;
        REG_CLIP_LO: reg_rdata <= clip_lo_q;
        REG_CLIP_HI: reg_rdata <= clip_hi_q;
        REG_PLANE_X: reg_rdata <= plane_x_q;
        REG_PLANE_Y: reg_rdata <= plane_y_q;
        REG_PARTIAL: reg_rdata <= partial_q;
        REG_STN_HS:  reg_rdata <= stn_hs_q;
        REG_STATUS: begin
          reg_rdata                            <= 32'h0;
          reg_rdata[11:0]                      <= v_cnt_q;
          reg_rdata[STAT_EMPTY_BIT]            <= q_empty;
          reg_rdata[STAT_FULL_BIT]             <= q_full;
          reg_rdata[STAT_LVL_LSB +: QUEUE_AW+1] <= q_lvl;
        end
        default:     reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // panel clock: two-flop sampling, third flop for edge finding
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pclk_s1_q         <= 1'b0;
      pclk_s2_q         <= 1'b0;
      pclk_s3_q         <= 1'b0;
      panel_pixel_clock <= 1'b0;
    end else begin
      pclk_s1_q         <= panel_pixel_clock_in;
      pclk_s2_q         <= pclk_s1_q;
      pclk_s3_q         <= pclk_s2_q;
      panel_pixel_clock <= pclk_s2_q & ~is_cpu;
    end
  end

  // column and line counters
  always_ff @(posedge core_clk) begin
    if (!rstn || !en || is_cpu) begin
      h_cnt_q <= 12'h0;
      v_cnt_q <= 12'h0;
    end else if (pix_tick) begin
      if (h_cnt_q >= h_total - 12'h1) begin
        h_cnt_q <= 12'h0;
        v_cnt_q <= (v_cnt_q >= v_total - 12'h1) ? 12'h0 : v_cnt_q + 12'h1;
      end else begin
        h_cnt_q <= h_cnt_q + 12'h1;
      end
    end
  end

  // logical sync and enable levels, taken from the counters at each panel edge
  always_ff @(posedge core_clk) begin
    if (!rstn || !en || is_cpu) begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      de_q <= 1'b0;
    end else if (pix_tick) begin
      if (is_tft) begin
        hs_q <= h_cnt_q < hsw;
        vs_q <= v_cnt_q < vsync_length;
        de_q <= active;
      end else begin
        hs_q <= !line_act && h_cnt_q >= stn_hs_q[11:0] && h_cnt_q < stn_hs_q[HI_FIELD_LSB +: 12];
        vs_q <= v_cnt_q == v_start;
        de_q <= 1'b0;
      end
    end
  end

  // STN bit gatherer: 3 color bits per pixel, 8 bits per panel edge
  always_ff @(posedge core_clk) begin
    if (!rstn || !en || !is_stn) begin
      sbuf_q <= 11'h0;
      scnt_q <= 4'h0;
    end else if (pix_tick && !line_act) begin
      scnt_q <= 4'h0;
    end else if (stn_emit) begin
      scnt_q <= scnt_q - 4'd8;
    end else if (stn_fetch) begin
      sbuf_q <= {sbuf_q[7:0], px_out[23], px_out[15], px_out[7]};
      scnt_q <= scnt_q + 4'd3;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pix_ack <= 1'b0;
    end else begin
      pix_ack <= tft_take || stn_fetch;
    end
  end

  // command queue
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (q_push) begin
        queue_q[wptr_q[QUEUE_AW-1:0]] <= reg_wdata[CMD_DATA_BIT:0];
        wptr_q                        <= wptr_q + 1'b1;
      end
      if (q_pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  // CPU bus cycle: setup, strobe, hold, each CPU_PHASE_CYC long
  always_ff @(posedge core_clk) begin
    if (!rstn || !en || !is_cpu) begin
      cpu_st_q <= CPU_IDLE;
      phase_q  <= 4'h0;
      rs_q     <= 1'b0;
    end else begin
      case (cpu_st_q)
        CPU_IDLE: begin
          if (q_pop) begin
            cpu_st_q <= CPU_SETUP;
            rs_q     <= q_head[CMD_DATA_BIT];
            phase_q  <= 4'(CPU_PHASE_CYC - 1);
          end
        end
        CPU_SETUP, CPU_STROBE, CPU_HOLD: begin
          if (phase_q != 4'h0) begin
            phase_q <= phase_q - 4'h1;
          end else begin
            phase_q  <= 4'(CPU_PHASE_CYC - 1);
            cpu_st_q <= cpu_st_q == CPU_SETUP ? CPU_STROBE : (cpu_st_q == CPU_STROBE ? CPU_HOLD : CPU_IDLE);
          end
        end
        default: cpu_st_q <= CPU_IDLE;
      endcase
    end
  end

  // panel data bus
  always_ff @(posedge core_clk) begin
    if (!rstn || !en) begin
      panel_data_bus <= 24'h0;
    end else if (is_cpu) begin
      if (q_pop) begin
        panel_data_bus <= ctrl_q[CTRL_CPU16_BIT] ? {8'h0, q_head[15:0]} : {16'h0, q_head[7:0]};
      end
    end else if (is_stn) begin
      if (stn_emit) begin
        panel_data_bus <= {16'h0, 8'(sbuf_q >> (scnt_q - 4'd8))};
      end else begin
        // upper lanes may still hold a TFT pixel after a mode change
        panel_data_bus[23:8] <= 16'h0;
      end
    end else if (pix_tick) begin
      if (!active) begin
        panel_data_bus <= 24'h0;
      end else if (in_plane && pix_valid && !pix_ack) begin
        panel_data_bus <= tft_px;
      end else begin
        panel_data_bus <= tft_bg;
      end
    end
  end

  // control pin mux
  wire cpu_cs = cpu_st_q != CPU_IDLE;
  wire cpu_st = cpu_st_q == CPU_STROBE;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {control_pin_3, control_pin_2, control_pin_1, control_pin_0} <= 4'h0;
      control_pin_upper <= 4'h0;
    end else if (gp_sel) begin
      {control_pin_3, control_pin_2, control_pin_1, control_pin_0} <= ctrl_q[CTRL_GPVAL_LSB +: 4];
      control_pin_upper <= ctrl_q[CTRL_GPVAL_LSB + 4 +: 4];
    end else begin
      control_pin_upper <= 4'h0;
      case (mode)
        MODE_TFT, MODE_STN: begin
          control_pin_0 <= vs_q ^ ctrl_q[CTRL_VSINV_BIT];
          control_pin_1 <= hs_q ^ ctrl_q[CTRL_HSINV_BIT];
          control_pin_2 <= is_tft & (de_q ^ ctrl_q[CTRL_DEINV_BIT]);
          control_pin_3 <= 1'b0;
        end
        MODE_CPU68: begin
          control_pin_0 <= rs_q;
          control_pin_1 <= ~cpu_cs;
          control_pin_2 <= cpu_st;
          control_pin_3 <= ~cpu_cs;
        end
        default: begin
          control_pin_0 <= rs_q;
          control_pin_1 <= ~cpu_st;
          control_pin_2 <= 1'b1;
          control_pin_3 <= ~cpu_cs;
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_hsync_line_start: assert property (en && is_tft && pix_tick && h_cnt_q == 12'h0 |=> hs_q)
    else $error("hsync missing at line start");
  a_valid_pin_polarity: assert property (!gp_sel && is_tft && $stable(ctrl_q)
    |=> control_pin_2 == ($past(de_q) ^ $past(ctrl_q[CTRL_DEINV_BIT])))
    else $error("data enable pin polarity wrong");
  a_vsync_length: assert property (en && is_tft && pix_tick && v_cnt_q < vsync_length |=> vs_q)
    else $error("vsync shorter than programmed length");
  a_stn_vsync_line: assert property (en && is_stn && pix_tick |=> vs_q == ($past(v_cnt_q) == $past(v_start)))
    else $error("stn vsync not on first active line");
  a_stn_hsync_idle: assert property (en && is_stn && pix_tick && line_act |=> !hs_q)
    else $error("stn hsync during active data");
  a_stn_low_byte: assert property (en && is_stn && $past(en && is_stn) |-> panel_data_bus[23:8] == 16'h0)
    else $error("stn data above low byte");
  a_gp_pins_out: assert property (gp_sel |=> control_pin_upper == $past(ctrl_q[CTRL_GPVAL_LSB + 4 +: 4]))
    else $error("general outputs not driven");
  a_bg_fill: assert property (tft_take == 1'b0 && en && is_tft && pix_tick && active && !in_plane
    |=> panel_data_bus == $past(tft_bg))
    else $error("background not shown outside plane");
  a_pixel_out: assert property (tft_take |=> panel_data_bus == $past(tft_px) ##1 pix_ack == 1'b0)
    else $error("taken pixel not driven");
  a_clip_limits: assert property (clip_lo_q[7:0] <= clip_hi_q[7:0]
    |-> px_out[7:0] >= clip_lo_q[7:0] && px_out[7:0] <= clip_hi_q[7:0])
    else $error("blue component outside clip limits");
  a_cpu_empty_stall: assert property (is_cpu && cpu_st_q == CPU_IDLE && q_empty |=> cpu_st_q == CPU_IDLE)
    else $error("bus cycle started with empty queue");
  a_cpu_select: assert property (!gp_sel && is_cpu && cpu_st_q == CPU_STROBE && $stable(ctrl_q)
    |=> control_pin_3 == 1'b0)
    else $error("chip select not low around strobe");

endmodule

/* bench/lpo_panel_model.sv */
// Purpose: panel side model, makes the pixel clock and counts lines
// Assumes: TFT pixel clock runs free at 160 ns
// Notes:   line count grows on each rising horizontal sync
module lpo_panel_model (
  output logic pclk,
  input  wire logic hs,
  output int   lines
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pclk = 1'b0;
    lines = 0;
    forever #80 pclk = ~pclk;
  end
  always @(posedge hs) begin
    lines++;
  end
endmodule

/* bench/lpo_formatter_tb.sv */
// Purpose: register, control pin and pixel format checks of the formatter
// Assumes: core clock 50 MHz, synchronous active low reset
// Notes:   short frames keep the run brief
module lpo_formatter_tb;
  import lpo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, reg_wr, reg_rd, pix_valid, pclk, pix_ack, p0, p1, p2, p3, ppc;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] pix_data, panel_data_bus;
  logic [3:0]  pup;
  logic [31:0] cfg [5] = '{32'h8009, 32'h8019, 32'h8041, 32'h8021, 32'h8101};
  int          lines, l0, n_mismatch, checks;
  lpo_formatter dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_data(pix_data), .pix_valid(pix_valid),
    .pix_ack(pix_ack), .panel_pixel_clock_in(pclk), .panel_pixel_clock(ppc), .panel_data_bus(panel_data_bus),
    .control_pin_0(p0), .control_pin_1(p1), .control_pin_2(p2), .control_pin_3(p3), .control_pin_upper(pup));
  lpo_panel_model panel (.pclk(pclk), .hs(p1), .lines(lines));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // wait for a signal to reach a level, bounded
  task automatic wsig(ref logic s, input logic v);
    #1;
    for (int i = 0; i < 4000 && s !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (s !== v) begin
      n_mismatch++;
      $display("MISMATCH %0t wait for level timed out", $time);
      stop_test();
    end
  endtask
  function automatic logic [23:0] fx(logic [31:0] c, logic [23:0] p);
    logic [7:0] a, g, b;
    a = c[4] ? p[7:0] : p[23:16];
    g = p[15:8];
    b = c[4] ? p[23:16] : p[7:0];
    if (c[3]) return {a, g, b};
    if (c[6]) return {a[7:2], a[7:6], g[7:2], g[7:6], b[7:2], b[7:6]};
    if (c[5]) return {a[7:3], a[7:5], g[7:2], g[7:6], b[7:3], b[7:5]};
    return {6'h00, a[7:6], a[5:2], g[7:4], g[3:2], b[7:2]};
  endfunction
  initial begin
    #600000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rstn, reg_wr, reg_rd, pix_valid} = 4'h0;
    reg_addr = 8'h00; reg_wdata = 32'h0; pix_data = 24'hC53A96;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rc(REG_HTIM, HTIM_RST); rc(REG_VTIM, VTIM_RST); rc(REG_CLIP_HI, CLIP_HI_RST); rc(8'h40, 32'h0);
    wr(REG_CTRL, 32'h00A5_0080);
    repeat (3) @(posedge core_clk);
    #1 chk({pup, p3, p2, p1, p0}, 32'hA5);
    wr(REG_CTRL, 32'h7);
    wr(REG_CMD, 32'h1_00A5);
    wsig(p3, 1'b0);
    chk({p0, p2, panel_data_bus[7:0]}, 32'h3A5);
    wsig(p1, 1'b0);
    chk(p3, 1'b0);
    wr(REG_HACT, 32'h8); wr(REG_VACT, 32'h4);
    pix_valid <= 1'b1;
    l0 = lines;
    foreach (cfg[i]) begin
      wr(REG_CTRL, cfg[i]);
      repeat (2) begin wsig(pix_ack, 1'b1); @(posedge core_clk); #1; end
      wsig(pix_ack, 1'b1);
      chk({ppc, panel_data_bus}, {1'b1, fx(cfg[i], pix_data)});
    end
    wr(REG_BRIGHT, 32'h10); wr(REG_CLIP_HI, 32'h80_FFFF);
    wr(REG_GAMMA, 32'h0A58);
    wr(REG_CTRL, 32'h9009);
    repeat (3) begin wsig(pix_ack, 1'b1); @(posedge core_clk); #1; end
    wsig(pix_ack, 1'b1);
    chk({ppc, panel_data_bus}, {1'b1, 24'h804CA6});
    // only column 0 stays inside the plane, column 1 must show the fill
    wr(REG_BG, 32'h12_3456);
    wr(REG_PLANE_X, 32'h0);
    repeat (2) @(posedge core_clk);
    wsig(pix_ack, 1'b1);
    repeat (8) @(posedge core_clk);
    #1 chk(panel_data_bus, 24'h123456);
    // first emit of the first STN line carries three gathered pixels
    wr(REG_CTRL, 32'h8003);
    repeat (10) @(posedge core_clk);
    wsig(p0, 1'b0);
    wsig(p0, 1'b1);
    wsig(pix_ack, 1'b1);
    repeat (7) @(posedge core_clk);
    #1 chk(panel_data_bus, 24'h0000B6);
    wr(REG_CTRL, 32'h805);
    wr(REG_CMD, 32'h1234);
    wsig(p2, 1'b1);
    chk({p0, p1, p3, ppc, panel_data_bus}, 32'h001234);
    rc(REG_STATUS, 32'h0001_0000);
    repeat (600) @(posedge core_clk);
    chk(lines > l0, 1);
    stop_test();
  end
endmodule
